// *** ddrio_buf2.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ddrio_buf2 #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output var logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	if (W < 1) begin
		$error("ddrio_buf2: width must be positive");
	end
	logic [W-1:0] mem_reg [2];
	logic [W-1:0] mem_next [2];
	logic wr_idx_reg, wr_idx_next, rd_idx_reg, rd_idx_next;
	logic [1:0] cnt_reg, cnt_next;
	logic in_ready_next, push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		mem_next = mem_reg;
		wr_idx_next = wr_idx_reg ^ push;
		rd_idx_next = rd_idx_reg ^ pop;
		if (push) begin
			mem_next[wr_idx_reg] = in_data;
		end
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
		// Ready is a flop so the source never waits on a long path
		in_ready_next = (cnt_next != 2'h2);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wr_idx_reg <= 1'b0;
			rd_idx_reg <= 1'b0;
			cnt_reg <= 2'h0;
			in_ready <= 1'b0;
		end else begin
			mem_reg <= mem_next;
			wr_idx_reg <= wr_idx_next;
			rd_idx_reg <= rd_idx_next;
			cnt_reg <= cnt_next;
			in_ready <= in_ready_next;
		end
	end

	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[rd_idx_reg];
endmodule
`default_nettype wire

// *** ddrio_datapath.sv ***
/*
 * Pin-side datapath to external DDR/DDR2/QDRII memory: write launch
 * with quadrature clocks, strobe-clocked read capture, parity, masks.
 * Assumes an external delay chain turns the tap and source outputs
 * into the delayed read strobe that arrives on rd_strobe_clk.
 */
// What this block does
// - Sustain 167 MHz, 333/667 Mbps memory transfers; mem_ck here runs at sys_clk / PHASES, a quarter of sys_clk
// - Strobe groups of x8, x9, x16, x18
// - Group: one strobe, one mask, nine data
// - x9 uses one lane like x8, x18 two like x16, plus ninth pins
// - Programmable delay centres read strobe in window
// - Delayed strobe clocks read data into registers
// - Accept bidirectional strobe or read clock
// - One parity bit per eight data bits
// - Mask low stores, high discards data
// - Each group drives its own mask pin
// - Two clock outputs: system and write clock
// - System clock times the write data
// - Write clock lags 90 degrees, times strobe
`timescale 1ns/1ps
`default_nettype none
module ddrio_datapath import ddrio_pkg::*; #(
	parameter int PAR_POS = PAR_POS_DEF,
	parameter int TAP_W = TAP_W_DEF
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Delayed read strobe
	input wire logic rd_strobe_clk,
	// Configuration
	input wire ddrio_mode_t cfg_mode,
	input wire logic cfg_parity_en,
	input wire logic [TAP_W-1:0] cfg_delay_tap,
	input wire logic cfg_use_rd_clk,
	input wire logic rd_enable,
	// Write stream
	input wire logic wr_valid,
	input wire ddrio_word_t wr_word,
	output var logic wr_ready,
	// Read stream
	output var logic rd_valid,
	output var ddrio_pair_t rd_pair,
	output var logic [2*LANES-1:0] rd_par_err,
	output var logic rd_overflow,
	input wire logic rd_ready,
	// Memory clocks and delay chain control
	output var logic mem_ck,
	output var logic wr_ck,
	output var logic [TAP_W-1:0] dly_tap,
	output var logic strobe_src,
	// Data, strobe and mask pins
	input wire logic [PIN_W-1:0] dq_in,
	output var logic [PIN_W-1:0] dq_out,
	output var logic [PIN_W-1:0] dq_oe,
	output var logic [LANES-1:0] dqs_out,
	output var logic [LANES-1:0] dqs_oe,
	output var logic [LANES-1:0] dm_out
);
	// ****************************************
	// Elaboration checks
	// ****************************************
	if (PAR_POS < 0 || PAR_POS >= LANE_W || TAP_W < 1) begin
		$error("ddrio_datapath: bad parity position or tap width");
	end
	if (MEM_CLK_MHZ > MEM_CLK_MAX_MHZ) begin
		$error("ddrio_datapath: memory clock above its limit");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [PIN_W-1:0] pins_used(ddrio_mode_t m);
		logic [PIN_W-1:0] u;
		u = PINS_OFF;
		for (int l = 0; l < LANES; l++) begin
			if (l == 0 || m == BUS_X16 || m == BUS_X18) begin
				for (int b = 0; b < LANE_W; b++) begin
					// Ninth pin idles in the narrow modes
					if (b < BYTE_W || m == BUS_X9 || m == BUS_X18) begin
						u[l*LANE_W+b] = 1'b1;
					end
				end
			end
		end
		return u;
	endfunction

	function automatic logic [LANES-1:0] lanes_used(ddrio_mode_t m);
		return (m == BUS_X16 || m == BUS_X18) ? 2'h3 : 2'h1;
	endfunction

	function automatic logic wide_lane(ddrio_mode_t m);
		return (m == BUS_X9 || m == BUS_X18);
	endfunction

	function automatic logic [AFIFO_AW:0] to_gray(logic [AFIFO_AW:0] b);
		return b ^ (b >> 1);
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************
	ddrio_mode_t mode_reg, mode_next;
	logic par_en_reg, par_en_next, rd_en_reg, rd_en_next;
	logic [TAP_W-1:0] dly_tap_next;
	logic strobe_src_next;

	always_comb begin
		mode_next = cfg_mode;
		par_en_next = cfg_parity_en && wide_lane(cfg_mode);
		rd_en_next = rd_enable;
		dly_tap_next = cfg_delay_tap;
		strobe_src_next = cfg_use_rd_clk;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= BUS_X8;
			par_en_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			dly_tap <= '0;
			strobe_src <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			par_en_reg <= par_en_next;
			rd_en_reg <= rd_en_next;
			dly_tap <= dly_tap_next;
			strobe_src <= strobe_src_next;
		end
	end

	// ****************************************
	// Quadrature clocks and write launch
	// ****************************************
	typedef enum logic [1:0] {W_IDLE, W_PRE, W_DATA, W_POST} ddrio_wst_t;
	ddrio_wst_t wst_reg, wst_next;
	logic [1:0] phase_reg, phase_next;
	logic mem_ck_next, wr_ck_next;
	logic [PIN_W-1:0] dq_out_next, dq_oe_next, par_data;
	logic [LANES-1:0] dqs_out_next, dqs_oe_next, dm_next;
	logic buf_valid, buf_pop;
	ddrio_word_t buf_word;

	// Stalling the launch fills the buffer and drops wr_ready
	ddrio_buf2 #(.W($bits(ddrio_word_t))) u_wbuf (
		.clk(sys_clk),
		.rst_b(rst_b),
		.in_valid(wr_valid),
		.in_data(wr_word),
		.in_ready(wr_ready),
		.out_valid(buf_valid),
		.out_data(buf_word),
		.out_ready(buf_pop)
	);

	always_comb begin
		phase_next = phase_reg + 2'h1;
		mem_ck_next = (phase_next >= PH_CK_HIGH);
		// One phase behind mem_ck is a quarter period of lag
		wr_ck_next = mem_ck;
		par_data = buf_word.data;
		for (int l = 0; l < LANES; l++) begin
			if (par_en_reg) begin
				par_data[l*LANE_W+PAR_POS] =
					^buf_word.data[l*LANE_W +: LANE_W] ^
					buf_word.data[l*LANE_W+PAR_POS];
			end
		end
		wst_next = wst_reg;
		buf_pop = 1'b0;
		dq_out_next = dq_out;
		dq_oe_next = dq_oe;
		dqs_out_next = dqs_out;
		dqs_oe_next = dqs_oe;
		dm_next = dm_out;
		unique case (wst_reg)
			W_IDLE: begin
				if (buf_valid && !phase_reg[0]) begin
					wst_next = W_PRE;
					dqs_oe_next = lanes_used(mode_reg);
					dqs_out_next = LANES_NONE;
				end
			end
			W_PRE, W_DATA: begin
				if (phase_reg[0]) begin
					// Data moves on the system clock's edges
					if (buf_valid) begin
						wst_next = W_DATA;
						buf_pop = 1'b1;
						dq_out_next = par_data & pins_used(mode_reg);
						dq_oe_next = pins_used(mode_reg);
						dm_next = buf_word.mask | ~lanes_used(mode_reg);
					end else if (wst_reg == W_DATA) begin
						wst_next = W_POST;
						dq_oe_next = PINS_OFF;
						dm_next = DM_ALL_MASKED;
					end
				end else if (wst_reg == W_DATA) begin
					// Strobe edges on the lagging clock's edges, a quarter after data
					dqs_out_next = ~dqs_out & lanes_used(mode_reg);
				end
			end
			W_POST: begin
				// An odd beat count leaves the strobe high; park it low
				dqs_out_next = LANES_NONE;
				if (!phase_reg[0]) begin
					wst_next = W_IDLE;
					dqs_oe_next = LANES_NONE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wst_reg <= W_IDLE;
			phase_reg <= PH_ZERO;
			mem_ck <= 1'b0;
			wr_ck <= 1'b0;
			dq_out <= PINS_OFF;
			dq_oe <= PINS_OFF;
			dqs_out <= LANES_NONE;
			dqs_oe <= LANES_NONE;
			dm_out <= DM_ALL_MASKED;
		end else begin
			wst_reg <= wst_next;
			phase_reg <= phase_next;
			mem_ck <= mem_ck_next;
			wr_ck <= wr_ck_next;
			dq_out <= dq_out_next;
			dq_oe <= dq_oe_next;
			dqs_out <= dqs_out_next;
			dqs_oe <= dqs_oe_next;
			dm_out <= dm_next;
		end
	end

	// ****************************************
	// Read capture on the strobe domain
	// ****************************************
	localparam int DEPTH = 1 << AFIFO_AW;
	logic en_meta_reg, en_sync_reg, en_sync_next;
	logic [PIN_W-1:0] rise_reg, rise_next;
	ddrio_pair_t fifo_reg [DEPTH];
	ddrio_pair_t fifo_next [DEPTH];
	logic [AFIFO_AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
	logic [AFIFO_AW:0] rq_meta_reg, rq_sync_reg;
	logic ovf_reg, ovf_next, full;
	logic [AFIFO_AW:0] rgray_reg;

	always_comb begin
		en_sync_next = en_meta_reg;
		rise_next = dq_in;
	end

	always_ff @(posedge rd_strobe_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_meta_reg <= 1'b0;
			en_sync_reg <= 1'b0;
			rise_reg <= PINS_OFF;
			rq_meta_reg <= '0;
		end else begin
			en_meta_reg <= rd_en_reg;
			en_sync_reg <= en_sync_next;
			rise_reg <= rise_next;
			// Meta stage on the rise: only a burst's first fall sees
			// the read pointer left from the burst before
			rq_meta_reg <= rgray_reg;
		end
	end

	always_comb begin
		full = (wgray_reg == {~rq_sync_reg[AFIFO_AW:AFIFO_AW-1],
			rq_sync_reg[AFIFO_AW-2:0]});
		fifo_next = fifo_reg;
		wbin_next = wbin_reg;
		ovf_next = ovf_reg;
		if (en_sync_reg) begin
			if (full) begin
				// No back-pressure reaches the memory; flag the loss
				ovf_next = 1'b1;
			end else begin
				fifo_next[wbin_reg[AFIFO_AW-1:0]] = {rise_reg, dq_in};
				wbin_next = wbin_reg + 1'b1;
			end
		end
		wgray_next = to_gray(wbin_next);
	end

	always_ff @(negedge rd_strobe_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				fifo_reg[i] <= '0;
			end
			wbin_reg <= '0;
			wgray_reg <= '0;
			rq_sync_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			fifo_reg <= fifo_next;
			wbin_reg <= wbin_next;
			wgray_reg <= wgray_next;
			rq_sync_reg <= rq_meta_reg;
			ovf_reg <= ovf_next;
		end
	end

	// ****************************************
	// Read hand-off to the system domain
	// ****************************************
	logic [AFIFO_AW:0] wq_meta_reg, wq_sync_reg, rbin_reg, rbin_next;
	logic [AFIFO_AW:0] rgray_next;
	logic ovf_meta_reg, take, rd_valid_next;
	ddrio_pair_t pair_sel, rd_pair_next;
	logic [2*LANES-1:0] par_err_next;
	logic [PIN_W-1:0] used;

	always_comb begin
		used = pins_used(mode_reg);
		take = (wq_sync_reg != rgray_reg) && (!rd_valid || rd_ready);
		pair_sel = fifo_reg[rbin_reg[AFIFO_AW-1:0]];
		rbin_next = rbin_reg + {{AFIFO_AW{1'b0}}, take};
		rgray_next = to_gray(rbin_next);
		rd_valid_next = rd_valid;
		rd_pair_next = rd_pair;
		par_err_next = rd_par_err;
		if (rd_valid && rd_ready) begin
			rd_valid_next = 1'b0;
		end
		if (take) begin
			rd_valid_next = 1'b1;
			rd_pair_next.rise = pair_sel.rise & used;
			rd_pair_next.fall = pair_sel.fall & used;
			for (int l = 0; l < LANES; l++) begin
				// A lane's first pin is in use whenever the lane is
				par_err_next[2*l] = par_en_reg && used[l*LANE_W] &&
					(^pair_sel.rise[l*LANE_W +: LANE_W]);
				par_err_next[2*l+1] = par_en_reg && used[l*LANE_W] &&
					(^pair_sel.fall[l*LANE_W +: LANE_W]);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wq_meta_reg <= '0;
			wq_sync_reg <= '0;
			rbin_reg <= '0;
			rgray_reg <= '0;
			ovf_meta_reg <= 1'b0;
			rd_overflow <= 1'b0;
			rd_valid <= 1'b0;
			rd_pair <= '0;
			rd_par_err <= '0;
		end else begin
			wq_meta_reg <= wgray_reg;
			wq_sync_reg <= wq_meta_reg;
			rbin_reg <= rbin_next;
			rgray_reg <= rgray_next;
			ovf_meta_reg <= ovf_reg;
			rd_overflow <= ovf_meta_reg;
			rd_valid <= rd_valid_next;
			rd_pair <= rd_pair_next;
			rd_par_err <= par_err_next;
		end
	end
endmodule
`default_nettype wire

// *** ddrio_mem_model.sv ***
/* Behavioural memory at the pins: stores write beats, sends reads.
   Assumes the bench calls burst and reads mem and beats. */
`timescale 1ns/1ps
`default_nettype none
module ddrio_mem_model import ddrio_pkg::*; (
	// Towards the device
	output var logic rd_strobe_clk,
	output var logic [PIN_W-1:0] dq_in,
	// From the device
	input wire logic [PIN_W-1:0] dq_out,
	input wire logic [PIN_W-1:0] dq_oe,
	input wire logic [LANES-1:0] dqs_out,
	input wire logic [LANES-1:0] dm_out
);
	// ****************************************
	// Write capture and read bursts
	// ****************************************
	logic [PIN_W-1:0] mem = PINS_OFF;
	int beats = 0;
	initial begin
		rd_strobe_clk = 1'b0;
		dq_in = PINS_OFF;
	end
	// Sampled on each strobe edge, mid-beat because of the lag
	always @(dqs_out) begin
		if (|dq_oe) begin
			for (int l = 0; l < LANES; l++) begin
				if (!dm_out[l])
					mem[l*LANE_W+:LANE_W] = dq_out[l*LANE_W+:LANE_W];
			end
			beats++;
		end
	end
	// Strobe stands still between bursts; bus then shows inverse
	task automatic burst(input int n, input logic [PIN_W-1:0] b);
		for (int i = 0; i < n; i++) begin
			dq_in = b + 18'(2*i);
			#3.75 rd_strobe_clk = 1'b1;
			#3.75 dq_in = b + 18'(2*i+1);
			#3.75 rd_strobe_clk = 1'b0;
			#3.75;
		end
		dq_in = ~dq_in;
	endtask
endmodule
`default_nettype wire

// *** ddrio_pkg.sv ***
/*
 * Constants, modes and carrier types of the memory pin datapath.
 * Assumes it is compiled before every design file that imports it.
 */
`default_nettype none
package ddrio_pkg;
	// ****************************************
	// Limits of the memory link
	// ****************************************
	localparam int MEM_CLK_MAX_MHZ = 167;
	localparam int DDR_MAX_MBPS = 333;
	localparam int QDR_MAX_MBPS = 667;
	localparam int SYS_CLK_MHZ = 50;
	localparam int SYS_PERIOD_NS = 20;
	// Sys cycles per memory clock period; one beat is half of it
	localparam int PHASES = 4;
	localparam int MEM_CLK_MHZ = SYS_CLK_MHZ / PHASES;

	// ****************************************
	// Pin groups
	// ****************************************
	localparam int LANES = 2;
	localparam int LANE_W = 9;
	localparam int BYTE_W = 8;
	localparam int PIN_W = LANES * LANE_W;
	localparam int PAR_POS_DEF = 8;
	localparam int TAP_W_DEF = 4;
	localparam int AFIFO_AW = 2;

	// ****************************************
	// Clock phase points and reset values
	// ****************************************
	localparam logic [1:0] PH_CK_HIGH = 2'h2;
	localparam logic [1:0] PH_ZERO = 2'h0;
	localparam logic [1:0] PH_ONE = 2'h1;
	localparam logic [PIN_W-1:0] PINS_OFF = 18'h00000;
	localparam logic [LANES-1:0] DM_ALL_MASKED = 2'h3;
	localparam logic [LANES-1:0] LANES_NONE = 2'h0;

	typedef enum logic [1:0] {
		BUS_X8,
		BUS_X9,
		BUS_X16,
		BUS_X18
	} ddrio_mode_t;

	// One write beat: pin-ordered data and one mask bit per lane
	typedef struct packed {
		logic [PIN_W-1:0] data;
		logic [LANES-1:0] mask;
	} ddrio_word_t;

	// Two read beats of one strobe cycle
	typedef struct packed {
		logic [PIN_W-1:0] rise;
		logic [PIN_W-1:0] fall;
	} ddrio_pair_t;
endpackage
`default_nettype wire

// *** ddrio_sva.sv ***
/* Port checker of the memory pin datapath.
   Assumes a bind onto ddrio_datapath in the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module ddrio_sva import ddrio_pkg::*; #(
	parameter int TAP_W = TAP_W_DEF
) (
	// Clock, reset, configuration
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [TAP_W-1:0] cfg_delay_tap,
	input wire logic cfg_use_rd_clk,
	// Read stream
	input wire logic rd_valid,
	input wire ddrio_pair_t rd_pair,
	input wire logic rd_overflow,
	input wire logic rd_ready,
	// Clocks, delay control, pins
	input wire logic mem_ck,
	input wire logic wr_ck,
	input wire logic [TAP_W-1:0] dly_tap,
	input wire logic strobe_src,
	input wire logic [PIN_W-1:0] dq_out,
	input wire logic [PIN_W-1:0] dq_oe,
	input wire logic [LANES-1:0] dqs_out,
	input wire logic [LANES-1:0] dqs_oe,
	input wire logic [LANES-1:0] dm_out
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_ck_period: assert property (
		$rose(mem_ck) |=> mem_ck ##1 !mem_ck ##1 !mem_ck ##1 mem_ck)
		else $error("memory clock period wrong");
	// Guarded by past reset: the first edge still shows reset values
	a_wr_lag: assert property (
		$past(rst_b) |-> wr_ck == $past(mem_ck))
		else $error("write clock not one cycle behind");
	a_tap_follow: assert property (
		$past(rst_b) |-> dly_tap == $past(cfg_delay_tap))
		else $error("delay tap not applied");
	a_src_follow: assert property (
		$past(rst_b) |-> strobe_src == $past(cfg_use_rd_clk))
		else $error("strobe source not applied");
	a_beat_stands: assert property (
		$changed(dq_out) |=> $stable(dq_out))
		else $error("write beat shorter than two cycles");
	a_dm_idle: assert property (
		dq_oe == PINS_OFF |-> dm_out == DM_ALL_MASKED)
		else $error("mask low while no data driven");
	a_lane_mask: assert property (
		|dq_oe |-> ((|dq_oe[8:0]) <= dqs_oe[0])
		&& ((|dq_oe[17:9]) <= dqs_oe[1]))
		else $error("lane driven without its strobe");
	a_strobe_pre: assert property (
		$rose(|dqs_oe) |-> dqs_out == LANES_NONE ##1 (|dq_oe))
		else $error("strobe preamble wrong");
	a_rd_hold: assert property (
		rd_valid && !rd_ready |=> rd_valid && $stable(rd_pair))
		else $error("read pair not held");
	a_ovf_sticky: assert property (
		rd_overflow |=> rd_overflow)
		else $error("overflow flag dropped");
	c_write: cover property (|dq_oe);
	c_read: cover property (rd_valid && rd_ready);
	c_ovf: cover property ($rose(rd_overflow));
endmodule
`default_nettype wire

// *** ddrio_tb.sv ***
/* Self-checking bench of the memory pin datapath.
   Assumes the package, design, checker and memory model compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb import ddrio_pkg::*;;
	// ****************************************
	// Signals, rows and tasks
	// ****************************************
	typedef struct packed {
		ddrio_mode_t m;
		logic p;
		logic [17:0] d;
		logic [1:0] k;
		logic [17:0] q;
		logic [1:0] dm;
	} ddrio_row_t;
	logic sys_clk, rst_b, rd_strobe_clk, cfg_parity_en, cfg_use_rd_clk;
	logic rd_enable, wr_valid, wr_ready, rd_valid, rd_overflow, rd_ready;
	logic mem_ck, wr_ck, strobe_src;
	ddrio_mode_t cfg_mode;
	logic [3:0] cfg_delay_tap, dly_tap, rd_par_err;
	ddrio_word_t wr_word;
	ddrio_pair_t rd_pair;
	logic [PIN_W-1:0] dq_in, dq_out, dq_oe;
	logic [LANES-1:0] dqs_out, dqs_oe, dm_out;
	int err_count = 0;
	int n_tests = 0;
	int b0;
	ddrio_row_t rows [6] = '{
		'{BUS_X8, 1'b0, 18'h3ffff, 2'h0, 18'h000ff, 2'h2},
		'{BUS_X9, 1'b0, 18'h3ffff, 2'h0, 18'h001ff, 2'h2},
		'{BUS_X16, 1'b0, 18'h3ffff, 2'h1, 18'h1feff, 2'h1},
		'{BUS_X18, 1'b0, 18'h2a5a5, 2'h2, 18'h2a5a5, 2'h2},
		'{BUS_X9, 1'b1, 18'h00007, 2'h0, 18'h00107, 2'h2},
		'{BUS_X18, 1'b1, 18'h00301, 2'h0, 18'h20301, 2'h0}};
	ddrio_datapath u_ddrio_datapath (.sys_clk, .rst_b, .rd_strobe_clk,
		.cfg_mode, .cfg_parity_en, .cfg_delay_tap, .cfg_use_rd_clk,
		.rd_enable, .wr_valid, .wr_word, .wr_ready, .rd_valid, .rd_pair,
		.rd_par_err, .rd_overflow, .rd_ready, .mem_ck, .wr_ck, .dly_tap,
		.strobe_src, .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .dm_out);
	ddrio_mem_model u_ddrio_mem_model (.rd_strobe_clk, .dq_in, .dq_out,
		.dq_oe, .dqs_out, .dm_out);
	task automatic cmp_w(input logic [35:0] got, input logic [35:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_s(input logic [3:0] got, input logic [3:0] exp);
		cmp_w(36'(got), 36'(exp));
	endtask
	task automatic end_of_test();
		$display("errors=%0d checks=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Valid held across words, so back-to-back words never glitch it
	task automatic push(input ddrio_word_t w, input int n);
		wr_valid = 1'b1;
		for (int i = 0; i < n; i++) begin
			wr_word = w;
			wr_word.data = w.data + 18'(i);
			while (wr_ready !== 1'b1) tick(1);
			tick(1);
		end
		wr_valid = 1'b0;
	endtask
	task automatic wait_oe();
		for (int i = 0; i < 20 && dq_oe === PINS_OFF; i++) tick(1);
	endtask
	function automatic logic [PIN_W-1:0] used(input ddrio_mode_t m);
		case (m)
			BUS_X8: used = 18'h000ff;
			BUS_X9: used = 18'h001ff;
			BUS_X16: used = 18'h1feff;
			default: used = 18'h3ffff;
		endcase
	endfunction
	task automatic rd_check(input int n, input logic [17:0] b,
		input logic [3:0] e);
		int g = 0;
		fork
			#7.3 u_ddrio_mem_model.burst(n, b);
			repeat (40) begin
				tick(1);
				if (rd_valid === 1'b1) begin
					cmp_w(rd_pair, {b + 18'(2*g), b + 18'(2*g+1)});
					cmp_s(rd_par_err, e);
					g++;
				end
			end
		join
		cmp_s(4'(g), 4'(n));
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
	initial begin
		{rst_b, cfg_parity_en, cfg_use_rd_clk, rd_enable} = 4'h0;
		{wr_valid, rd_ready, cfg_delay_tap} = 6'h00;
		cfg_mode = BUS_X18;
		wr_word = '0;
		tick(4);
		cmp_s({dm_out, dqs_oe}, 4'hc);
		cmp_s({3'h0, wr_ready}, 4'h0);
		rst_b = 1'b1;
		foreach (rows[i]) begin
			cfg_mode = rows[i].m;
			cfg_parity_en = rows[i].p;
			tick(2);
			push('{rows[i].d, rows[i].k}, 1);
			wait_oe();
			cmp_w(36'(dq_out & dq_oe), 36'(rows[i].q));
			cmp_w(36'(dq_oe), 36'(used(rows[i].m)));
			cmp_s({2'h0, dm_out}, {2'h0, rows[i].dm});
			tick(8);
		end
		cfg_mode = BUS_X18;
		cfg_parity_en = 1'b0;
		b0 = u_ddrio_mem_model.beats;
		tick(2);
		push('{18'h12345, 2'h0}, 3);
		tick(20);
		cmp_s(4'(u_ddrio_mem_model.beats - b0), 4'h3);
		cmp_w(36'(u_ddrio_mem_model.mem), 36'(18'h12347));
		cmp_s({dqs_out, dqs_oe}, 4'h0);
		cfg_delay_tap = 4'ha;
		cfg_use_rd_clk = 1'b1;
		rd_enable = 1'b1;
		rd_ready = 1'b1;
		tick(2);
		cmp_s(dly_tap, 4'ha);
		cmp_s({3'h0, strobe_src}, 4'h1);
		u_ddrio_mem_model.burst(4, 18'h0);
		tick(20);
		rd_check(3, 18'h01000, 4'h0);
		cfg_mode = BUS_X9;
		cfg_parity_en = 1'b1;
		tick(2);
		rd_check(1, 18'h00000, 4'h2);
		cfg_mode = BUS_X18;
		cfg_parity_en = 1'b0;
		rd_ready = 1'b0;
		tick(2);
		u_ddrio_mem_model.burst(10, 18'h0);
		tick(4);
		cmp_s({3'h0, rd_overflow}, 4'h1);
		rd_ready = 1'b1;
		tick(12);
		cmp_s({2'h0, rd_overflow, rd_valid}, 4'h2);
		rst_b = 1'b0;
		tick(1);
		cmp_s({rd_overflow, rd_valid, dm_out}, 4'h3);
		rst_b = 1'b1;
		tick(2);
		cmp_s({rd_overflow, rd_valid, wr_ready, dqs_oe[0]}, 4'h2);
		end_of_test();
	end
endmodule
bind ddrio_datapath ddrio_sva #(.TAP_W(TAP_W)) u_ddrio_sva (.sys_clk,
	.rst_b, .cfg_delay_tap, .cfg_use_rd_clk, .rd_valid, .rd_pair,
	.rd_overflow, .rd_ready, .mem_ck, .wr_ck, .dly_tap, .strobe_src,
	.dq_out, .dq_oe, .dqs_out, .dqs_oe, .dm_out);
`default_nettype wire
